/* File: hpb_slice.sv */
// One 16/32-bit slice of the host bridge datapath with its five buffers.
// Assumes the bridge controller shares clk_i and issues command groups.
`default_nettype none
module hpb_slice #(
  parameter bit TRDY_WIRED = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Command groups, role strap and TRDY
  input wire logic [4:0] host_command_group_i,
  input wire logic [2:0] memory_command_group_i,
  input wire logic [3:0] pci_command_group_i,
  input wire logic end_of_line_warning_i,
  input wire logic trdy_b_i,
  // Host data and address slice
  input wire logic [31:0] hd_i,
  input wire logic [3:0] hp_i,
  output logic [31:0] hd_o,
  output logic [3:0] hp_o,
  output logic hd_oe_b_o,
  input wire logic [15:0] ha_i,
  output logic [15:0] ha_o,
  output logic ha_oe_b_o,
  // Memory data slice
  input wire logic [31:0] md_i,
  input wire logic [3:0] mp_i,
  output logic [31:0] md_o,
  output logic [3:0] mp_o,
  output logic md_oe_b_o,
  // PCI address/data slice
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic ad_oe_b_o,
  output logic pci_ppar_o,
  // Status
  output logic high_slice_o,
  output logic host_perr_o,
  output logic mem_perr_o
);
  // Even byte parity over one slice word
  function automatic logic [3:0] par4(input logic [31:0] d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++)
    begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction : par4

  typedef struct packed {
    logic eol_s1;
    logic eol_s2;
    logic trdy_s1;
    logic trdy_s2;
    logic [1:0] strap_cnt;
    logic high_slice;
    logic [2:0] cmw_wp;
    logic [2:0] cmw_rp;
    logic [3:0] pmw_wp;
    logic [3:0] pmw_rp;
    logic [1:0][15:0] pmw_addr;
    logic [2:0] pmr_wp;
    logic [3:0] pmr_rp;
    logic [2:0] cpw_wp;
    logic [2:0] cpw_rp;
    logic [15:0] cpw_addr;
    logic [2:0] cpr_wp;
    logic [2:0] cpr_rp;
    logic [35:0] mlat;
    hpb_pkg::hpb_st_t st;
    logic [31:0] hd;
    logic [3:0] hp;
    logic hd_oe_b;
    logic [15:0] ha;
    logic ha_oe_b;
    logic [31:0] md;
    logic [3:0] mp;
    logic md_oe_b;
    logic [15:0] ad;
    logic ad_oe_b;
    logic ppar;
    logic host_perr;
    logic mem_perr;
  } hpb_state_t;

  hpb_state_t r_ff, nxt_r;

  hpb_mem_if #(.W(36), .AW(2)) cmw_if ();
  hpb_mem_if #(.W(18), .AW(3)) pmw_if ();
  hpb_mem_if #(.W(36), .AW(2)) pmr_if ();
  hpb_mem_if #(.W(16), .AW(2)) cpw_if ();
  hpb_mem_if #(.W(16), .AW(2)) cpr_if ();

  hpb_mem #(.W(36), .DEPTH(hpb_pkg::CMW_DEPTH), .AW(2)) u_cmw (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port(cmw_if));
  hpb_mem #(.W(18), .DEPTH(hpb_pkg::PMW_DEPTH), .AW(3)) u_pmw (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port(pmw_if));
  hpb_mem #(.W(36), .DEPTH(hpb_pkg::PMR_DEPTH), .AW(2)) u_pmr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port(pmr_if));
  hpb_mem #(.W(16), .DEPTH(hpb_pkg::CPW_DEPTH), .AW(2)) u_cpw (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port(cpw_if));
  hpb_mem #(.W(16), .DEPTH(hpb_pkg::CPR_DEPTH), .AW(2)) u_cpr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .port(cpr_if));

  // Fill and drain state of the three write buffers, drain state of the two read buffers
  logic cmw_full, cmw_empty, pmw_full, pmw_empty, pmr_empty;
  logic cpw_full, cpw_empty, cpr_empty, burst_pop;
  assign cmw_full = (r_ff.cmw_wp ^ r_ff.cmw_rp) == 3'h4;
  assign cmw_empty = r_ff.cmw_wp == r_ff.cmw_rp;
  assign pmw_full = (r_ff.pmw_wp ^ r_ff.pmw_rp) == 4'h8;
  assign pmw_empty = r_ff.pmw_wp == r_ff.pmw_rp;
  assign pmr_empty = r_ff.pmr_wp == r_ff.pmr_rp[3:1];
  assign cpw_full = (r_ff.cpw_wp ^ r_ff.cpw_rp) == 3'h4;
  assign cpw_empty = r_ff.cpw_wp == r_ff.cpw_rp;
  assign cpr_empty = r_ff.cpr_wp == r_ff.cpr_rp;
  // TRDY low in a data burst moves the next posted dword out unasked
  assign burst_pop = TRDY_WIRED && r_ff.st == hpb_pkg::ST_DATA
                     && !r_ff.trdy_s2 && !cpw_empty;

  // Buffer write ports follow the command groups directly
  always_comb
  begin
    cmw_if.we = host_command_group_i == hpb_pkg::HC_MEMW
                && !cmw_full;
    cmw_if.waddr = r_ff.cmw_wp[1:0];
    cmw_if.wdata = {hp_i, hd_i};
    pmw_if.we = pci_command_group_i == hpb_pkg::PC_MDATA
                && !pmw_full;
    pmw_if.waddr = r_ff.pmw_wp[2:0];
    pmw_if.wdata = {^ad_i[15:8], ^ad_i[7:0], ad_i};
    pmr_if.we = memory_command_group_i == hpb_pkg::MC_PFL
                && (r_ff.pmr_wp ^ r_ff.pmr_rp[3:1]) != 3'h4;
    pmr_if.waddr = r_ff.pmr_wp[1:0];
    pmr_if.wdata = {mp_i, md_i};
    cpw_if.we = (host_command_group_i == hpb_pkg::HC_PCIW_LO
                 || host_command_group_i == hpb_pkg::HC_PCIW_HI)
                && !cpw_full;
    cpw_if.waddr = r_ff.cpw_wp[1:0];
    // Dword select picks word one or three of this slice's pair
    cpw_if.wdata = host_command_group_i == hpb_pkg::HC_PCIW_HI ?
                   hd_i[31:16] : hd_i[15:0];
    cpr_if.we = pci_command_group_i == hpb_pkg::PC_RDAT
                && (r_ff.cpr_wp ^ r_ff.cpr_rp) != 3'h4;
    cpr_if.waddr = r_ff.cpr_wp[1:0];
    cpr_if.wdata = ad_i;
    // Read next state's head so popped data is ready one edge later
    cmw_if.raddr = nxt_r.cmw_rp[1:0];
    pmw_if.raddr = nxt_r.pmw_rp[2:0];
    pmr_if.raddr = nxt_r.pmr_rp[2:1];
    cpw_if.raddr = nxt_r.cpw_rp[1:0];
    cpr_if.raddr = nxt_r.cpr_rp[1:0];
  end

  // Next state of the whole slice
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.eol_s1 = end_of_line_warning_i;
    nxt_r.eol_s2 = r_ff.eol_s1;
    nxt_r.trdy_s1 = trdy_b_i;
    nxt_r.trdy_s2 = r_ff.trdy_s1;
    nxt_r.host_perr = 1'b0;
    nxt_r.mem_perr = 1'b0;
    // Role strap caught once the synchroniser holds a settled level
    if (r_ff.strap_cnt != hpb_pkg::STRAP_EDGE)
    begin
      nxt_r.strap_cnt = r_ff.strap_cnt + 2'h1;
      if (r_ff.strap_cnt == hpb_pkg::STRAP_EDGE - 2'h1)
      begin
        nxt_r.high_slice = r_ff.eol_s2;
      end
    end
    if (cmw_if.we)
    begin
      nxt_r.cmw_wp = r_ff.cmw_wp + 3'h1;
      nxt_r.host_perr = par4(hd_i) != hp_i;
    end
    if (pmw_if.we)
    begin
      nxt_r.pmw_wp = r_ff.pmw_wp + 4'h1;
    end
    if (pmr_if.we)
    begin
      nxt_r.pmr_wp = r_ff.pmr_wp + 3'h1;
    end
    if (cpw_if.we)
    begin
      nxt_r.cpw_wp = r_ff.cpw_wp + 3'h1;
    end
    if (cpr_if.we)
    begin
      nxt_r.cpr_wp = r_ff.cpr_wp + 3'h1;
    end

    // Host group; unknown codes fall to default and change nothing
    case (host_command_group_i)
      hpb_pkg::HC_ADDR:
      begin
        nxt_r.cpw_addr = ha_i;
      end
      hpb_pkg::HC_DRV_PFB:
      begin
        // Same dword on both halves for either qword position
        if (!cpr_empty)
        begin
          nxt_r.hd = {cpr_if.rdata, cpr_if.rdata};
          nxt_r.hp = par4({cpr_if.rdata, cpr_if.rdata});
          nxt_r.hd_oe_b = 1'b0;
          nxt_r.cpr_rp = r_ff.cpr_rp + 3'h1;
        end
      end
      hpb_pkg::HC_DRV_MEM:
      begin
        nxt_r.hd = r_ff.mlat[31:0];
        nxt_r.hp = r_ff.mlat[35:32];
        nxt_r.hd_oe_b = 1'b0;
      end
      hpb_pkg::HC_SNOOP:
      begin
        // Inquire address is the PCI master address now draining
        nxt_r.ha = r_ff.pmw_addr[r_ff.pmw_rp[2]];
        nxt_r.ha_oe_b = 1'b0;
      end
      hpb_pkg::HC_OFF:
      begin
        nxt_r.hd_oe_b = 1'b1;
        nxt_r.ha_oe_b = 1'b1;
      end
      default:
      begin
      end
    endcase

    // Memory group
    case (memory_command_group_i)
      hpb_pkg::MC_HLAT:
      begin
        nxt_r.mlat = {mp_i, md_i};
        nxt_r.mem_perr = par4(md_i) != mp_i;
      end
      hpb_pkg::MC_PFL:
      begin
        nxt_r.mem_perr = par4(md_i) != mp_i;
      end
      hpb_pkg::MC_DRV_CPU:
      begin
        if (!cmw_empty)
        begin
          nxt_r.md = cmw_if.rdata[31:0];
          nxt_r.mp = cmw_if.rdata[35:32];
          nxt_r.md_oe_b = 1'b0;
          nxt_r.cmw_rp = r_ff.cmw_rp + 3'h1;
        end
      end
      hpb_pkg::MC_DRV_PCI:
      begin
        // One PCI word lands on both word lanes; controller masks bytes
        if (!pmw_empty)
        begin
          nxt_r.md = {2{pmw_if.rdata[15:0]}};
          nxt_r.mp = {2{pmw_if.rdata[17:16]}};
          nxt_r.md_oe_b = 1'b0;
          nxt_r.pmw_rp = r_ff.pmw_rp + 4'h1;
        end
      end
      hpb_pkg::MC_OFF:
      begin
        nxt_r.md_oe_b = 1'b1;
      end
      hpb_pkg::MC_CLR:
      begin
        nxt_r.cmw_rp = r_ff.cmw_wp;
        nxt_r.pmr_rp = {r_ff.pmr_wp, 1'b0};
      end
      default:
      begin
      end
    endcase

    // PCI group; TRDY is the only PCI control pin, only these codes and a TRDY burst steer AD
    case (pci_command_group_i)
      hpb_pkg::PC_MADDR:
      begin
        // A new single post skips to the other line buffer
        if (r_ff.pmw_wp[1:0] != 2'h0)
        begin
          nxt_r.pmw_wp = {r_ff.pmw_wp[3:2] + 2'h1, 2'h0};
        end
        nxt_r.pmw_addr[nxt_r.pmw_wp[2]] = ad_i;
        nxt_r.ppar = ^ad_i;
      end
      hpb_pkg::PC_MDATA, hpb_pkg::PC_RDAT:
      begin
        nxt_r.ppar = ^ad_i;
      end
      hpb_pkg::PC_DRV_ADDR:
      begin
        nxt_r.ad = r_ff.cpw_addr;
        nxt_r.ad_oe_b = 1'b0;
        nxt_r.ppar = ^r_ff.cpw_addr;
        nxt_r.st = hpb_pkg::ST_ADDR;
      end
      hpb_pkg::PC_DRV_WD:
      begin
        if (!cpw_empty)
        begin
          nxt_r.ad = cpw_if.rdata;
          nxt_r.ad_oe_b = 1'b0;
          nxt_r.ppar = ^cpw_if.rdata;
          nxt_r.cpw_rp = r_ff.cpw_rp + 3'h1;
          nxt_r.st = hpb_pkg::ST_DATA;
        end
      end
      hpb_pkg::PC_DRV_PF:
      begin
        // Low half then high half of each qword slice: eight dwords
        if (!pmr_empty)
        begin
          nxt_r.ad = r_ff.pmr_rp[0] ? pmr_if.rdata[31:16]
                                    : pmr_if.rdata[15:0];
          nxt_r.ad_oe_b = 1'b0;
          nxt_r.ppar = r_ff.pmr_rp[0] ? ^pmr_if.rdata[31:16]
                                      : ^pmr_if.rdata[15:0];
          nxt_r.pmr_rp = r_ff.pmr_rp + 4'h1;
        end
      end
      hpb_pkg::PC_OFF:
      begin
        nxt_r.ad_oe_b = 1'b1;
        nxt_r.st = hpb_pkg::ST_IDLE;
      end
      hpb_pkg::PC_FLUSH:
      begin
        nxt_r.cpr_rp = r_ff.cpr_wp;
        nxt_r.pmr_rp = {r_ff.pmr_wp, 1'b0};
        nxt_r.st = hpb_pkg::ST_IDLE;
      end
      default:
      begin
        if (burst_pop)
        begin
          nxt_r.ad = cpw_if.rdata;
          nxt_r.ppar = ^cpw_if.rdata;
          nxt_r.cpw_rp = r_ff.cpw_rp + 3'h1;
        end
      end
    endcase
  end

  // Single state register; all buses released at reset
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r_ff <= '0;
      r_ff.eol_s1 <= 1'b0;
      r_ff.trdy_s1 <= 1'b1;
      r_ff.trdy_s2 <= 1'b1;
      r_ff.st <= hpb_pkg::ST_IDLE;
      r_ff.hd <= hpb_pkg::DATA_RESET;
      r_ff.md <= hpb_pkg::DATA_RESET;
      r_ff.hd_oe_b <= 1'b1;
      r_ff.ha_oe_b <= 1'b1;
      r_ff.md_oe_b <= 1'b1;
      r_ff.ad_oe_b <= 1'b1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state register
  assign hd_o = r_ff.hd;
  assign hp_o = r_ff.hp;
  assign hd_oe_b_o = r_ff.hd_oe_b;
  assign ha_o = r_ff.ha;
  assign ha_oe_b_o = r_ff.ha_oe_b;
  assign md_o = r_ff.md;
  assign mp_o = r_ff.mp;
  assign md_oe_b_o = r_ff.md_oe_b;
  assign ad_o = r_ff.ad;
  assign ad_oe_b_o = r_ff.ad_oe_b;
  assign pci_ppar_o = r_ff.ppar;
  assign high_slice_o = r_ff.high_slice;
  assign host_perr_o = r_ff.host_perr;
  assign mem_perr_o = r_ff.mem_perr;

  // Checks on the slice's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_cmw_refuse;
    cmw_full && host_command_group_i == hpb_pkg::HC_MEMW
      && memory_command_group_i != hpb_pkg::MC_DRV_CPU
      |=> $stable(r_ff.cmw_wp);
  endproperty
  a_cmw_refuse: assert property (p_cmw_refuse)
    else $error("write buffer accepted a quadword while full");

  property p_cpw_depth;
    (r_ff.cpw_wp - r_ff.cpw_rp) <= 3'h4;
  endproperty
  a_cpw_depth: assert property (p_cpw_depth)
    else $error("posted PCI write buffer over four dwords");

  property p_pf_drive;
    pci_command_group_i == hpb_pkg::PC_DRV_PF && !pmr_empty
      |=> !ad_oe_b_o && ad_o == ($past(r_ff.pmr_rp[0]) ?
          $past(pmr_if.rdata[31:16]) : $past(pmr_if.rdata[15:0]));
  endproperty
  a_pf_drive: assert property (p_pf_drive)
    else $error("prefetch half not driven on AD");

  property p_addr_drive;
    pci_command_group_i == hpb_pkg::PC_DRV_ADDR
      |=> ad_o == $past(r_ff.cpw_addr) && !ad_oe_b_o
          && r_ff.st == hpb_pkg::ST_ADDR;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("stored write address not driven on AD");

  property p_strap_hold;
    r_ff.strap_cnt == hpb_pkg::STRAP_EDGE |=> $stable(high_slice_o);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("slice role changed after reset");

  property p_nop;
    host_command_group_i > 5'h08 && memory_command_group_i == 3'h7
      && pci_command_group_i > 4'h8 && !burst_pop
      |=> $stable(hd_o) && $stable(md_o) && $stable(ad_o)
          && $stable(ad_oe_b_o);
  endproperty
  a_nop: assert property (p_nop)
    else $error("unassigned command altered outputs");

  property p_md_par;
    memory_command_group_i == hpb_pkg::MC_DRV_CPU && !cmw_empty
      |=> mp_o == $past(cmw_if.rdata[35:32]) && !md_oe_b_o;
  endproperty
  a_md_par: assert property (p_md_par)
    else $error("memory parity not carried from host write");

  property p_pci_par;
    !ad_oe_b_o && $changed(ad_o) |-> pci_ppar_o == ^ad_o;
  endproperty
  a_pci_par: assert property (p_pci_par)
    else $error("PCI partial parity wrong for driven word");

  property p_burst;
    burst_pop && pci_command_group_i == hpb_pkg::PC_NOP
      |=> r_ff.cpw_rp == $past(r_ff.cpw_rp) + 3'h1;
  endproperty
  a_burst: assert property (p_burst)
    else $error("TRDY burst did not advance posted data");

  c_full_line: cover property (cmw_full ##1 !cmw_empty [*4]);
  c_burst: cover property (burst_pop [*3]);
  c_pf_eight: cover property (pmr_if.we ##1 !pmr_empty [*8]);
endmodule : hpb_slice
`default_nettype wire

/* File: hpb_pkg.sv */
// Constants, command codes and state types for the host bridge data slice.
// Assumes one 50 MHz clock shared by the slice and its bridge controller.
// Functional notes
// - Processor-to-memory write buffer holds four quadwords, one per clock.
// - PCI-to-memory write buffer: two 4-dword lines or two single posts.
// - PCI memory reads prefetch four quadwords, delivered as eight dwords.
// - Processor-to-PCI write buffer accepts up to four dwords.
// - Processor-to-PCI read prefetch buffer is four dwords deep.
// - Only the two PCI-facing write buffers also keep addresses.
// - Five-bit host command group decodes host latch and steer commands.
// - Three-bit memory command group decodes seven memory commands.
// - Four-bit PCI command group decodes PCI data and address commands.
// - Slice carries 16 PCI bits and 32 bits of host and memory data.
// - Low slice takes host/memory words one and three, high two and four.
// - Low slice sits on low PCI half, high slice on high half.
// - Low slice drives host address 15..0, high slice 31..16.
// - TRDY is the only PCI control input; drive AD outbound, latch AD inbound.
// - With TRDY wired, sequential posted writes burst with no waits.
// - Byte parity generated on host and memory data; checked on memory data and on host writes to memory.
// - PCI parity produced for address and data phases.
// - Slice learns high or low role from end-of-line warning at reset.
`default_nettype none
package hpb_pkg;
  localparam int CMW_DEPTH = 4;
  localparam int PMW_DEPTH = 8;
  localparam int PMR_DEPTH = 4;
  localparam int CPW_DEPTH = 4;
  localparam int CPR_DEPTH = 4;
  localparam int HOST_CMD_COUNT = 29;
  localparam int MEM_CMD_COUNT = 7;
  localparam int PCI_CMD_COUNT = 15;
  localparam logic [1:0] STRAP_EDGE = 2'h3;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    HC_NOP = 5'h00, HC_MEMW = 5'h01, HC_PCIW_LO = 5'h02,
    HC_PCIW_HI = 5'h03, HC_ADDR = 5'h04, HC_DRV_PFB = 5'h05,
    HC_DRV_MEM = 5'h06, HC_SNOOP = 5'h07, HC_OFF = 5'h08
  } hpb_hcmd_t;

  typedef enum logic [2:0] {
    MC_NOP = 3'h0, MC_PFL = 3'h1, MC_HLAT = 3'h2, MC_DRV_CPU = 3'h3,
    MC_DRV_PCI = 3'h4, MC_OFF = 3'h5, MC_CLR = 3'h6
  } hpb_mcmd_t;

  typedef enum logic [3:0] {
    PC_NOP = 4'h0, PC_MADDR = 4'h1, PC_MDATA = 4'h2, PC_DRV_ADDR = 4'h3,
    PC_DRV_WD = 4'h4, PC_RDAT = 4'h5, PC_DRV_PF = 4'h6, PC_OFF = 4'h7,
    PC_FLUSH = 4'h8
  } hpb_pcmd_t;

  // Gray along idle, address phase, data burst
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ADDR = 2'h1, ST_DATA = 2'h3
  } hpb_st_t;
endpackage : hpb_pkg
`default_nettype wire

/* File: hpb_mem_if.sv */
// Write and read port bundle between slice control and one buffer memory.
// Assumes the memory registers its read data every clock.
`default_nettype none
interface hpb_mem_if #(parameter int W = 16, parameter int AW = 2);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : hpb_mem_if
`default_nettype wire

/* File: hpb_mem.sv */
// Small buffer memory with registered, write-first read data.
// Assumes the controller presents next-cycle read addresses.
`default_nettype none
module hpb_mem #(
  parameter int W = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Buffer port
  hpb_mem_if.mem port
);
  logic [W-1:0] store [DEPTH];

  // Storage has no reset; pointers guard stale entries
  always_ff @(posedge clk_i)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
  end

  // Write-first so a pop right behind a push sees fresh data
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      port.rdata <= '0;
    end
    else if (port.we && port.waddr == port.raddr)
    begin
      port.rdata <= port.wdata;
    end
    else
    begin
      port.rdata <= store[port.raddr];
    end
  end
endmodule : hpb_mem
`default_nettype wire

/* File: hpb_far_model.sv */
// Far side of the slice: memory data bus and PCI AD half as data sources.
// Assumes the bench says in which cycles each bus carries valid data.
`default_nettype none
module hpb_far_model (
  // Clock
  input wire logic clk_i,
  // Requests from the bench
  input wire logic md_en_i,
  input wire logic [31:0] md_val_i,
  input wire logic ad_en_i,
  input wire logic [15:0] ad_val_i,
  // Lines toward the slice
  output logic [31:0] md_o,
  output logic [3:0] mp_o,
  output logic [15:0] ad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_md = 32'h0000_0000;
  logic [15:0] last_ad = 16'h0000;

  // Released lines toggle each cycle, so a late latch never sees old data
  always_comb
  begin
    md_o = md_en_i ? md_val_i : ~last_md;
    ad_o = ad_en_i ? ad_val_i : ~last_ad;
  end

  // Memory side keeps even byte parity on what it drives
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      mp_o[i] = ^md_o[8*i +: 8];
  end

  // Last seen values for the release pattern
  always @(posedge clk_i)
  begin
    last_md <= md_o;
    last_ad <= ad_o;
  end
endmodule : hpb_far_model
`default_nettype wire

/* File: host_pci_memory_data_slice_bench.sv */
// Self-checking bench for one host bridge data slice.
// Assumes the slice package and the far side model are compiled first.
`default_nettype none
module host_pci_memory_data_slice_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, strap, trdy_b, md_en, ad_en;
  logic [4:0] hcmd;
  logic [2:0] mcmd;
  logic [3:0] pcmd;
  logic [31:0] hd_i, md_val, md_i, hd_o, md_o;
  logic [3:0] hp_i, mp_i, hp_o, mp_o;
  logic [15:0] ha_i, ad_val, ad_i, ha_o, ad_o;
  logic hd_oe_b, ha_oe_b, md_oe_b, ad_oe_b, ppar, high, h_perr, m_perr;
  int mismatches = 0;
  int n_tests = 0;

  // Device under test
  hpb_slice #(.TRDY_WIRED(1'b1)) u_hpb_slice (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .host_command_group_i(hcmd),
    .memory_command_group_i(mcmd), .pci_command_group_i(pcmd),
    .end_of_line_warning_i(strap), .trdy_b_i(trdy_b), .hd_i(hd_i),
    .hp_i(hp_i), .hd_o(hd_o), .hp_o(hp_o), .hd_oe_b_o(hd_oe_b),
    .ha_i(ha_i), .ha_o(ha_o), .ha_oe_b_o(ha_oe_b), .md_i(md_i),
    .mp_i(mp_i), .md_o(md_o), .mp_o(mp_o), .md_oe_b_o(md_oe_b),
    .ad_i(ad_i), .ad_o(ad_o), .ad_oe_b_o(ad_oe_b), .pci_ppar_o(ppar),
    .high_slice_o(high), .host_perr_o(h_perr), .mem_perr_o(m_perr));

  // Memory and PCI far side
  hpb_far_model u_hpb_far_model (.clk_i(clk_i), .md_en_i(md_en),
    .md_val_i(md_val), .ad_en_i(ad_en), .ad_val_i(ad_val), .md_o(md_i),
    .mp_o(mp_i), .ad_o(ad_i));

  // 50 MHz clock
  always
  begin
    #10;
    clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Commands change only at the falling edge
  task automatic step(input logic [4:0] h, input logic [2:0] m,
    input logic [3:0] p);
    @(negedge clk_i);
    hcmd = h;
    mcmd = m;
    pcmd = p;
  endtask : step

  task automatic nop();
    step(5'h00, 3'h0, 4'h0);
  endtask : nop

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  function automatic logic [3:0] par4(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      par4[i] = ^d[8*i +: 8];
  endfunction : par4

  // One AD drive, then its data and, a cycle on, its parity
  task automatic ad_pop(input logic [3:0] p, input logic [15:0] exp);
    step(5'h00, 3'h0, p);
    nop();
    settle();
    chk("ad_o", {16'h0000, exp}, {16'h0000, ad_o});
    chk("ad_oe_b", 32'h0, {31'h0, ad_oe_b});
    nop();
    settle();
    chk("ppar", {31'h0, ^exp}, {31'h0, ppar});
  endtask : ad_pop

  task automatic test_role(input logic s);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    strap = s;
    repeat (20) @(negedge clk_i);
    chk("oe in reset", 32'hF,
      {28'h0, hd_oe_b, ha_oe_b, md_oe_b, ad_oe_b});
    chk("role in reset", 32'h0, {31'h0, high});
    rst_b_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("role", {31'h0, s}, {31'h0, high});
    $display("test role %0d done", s);
  endtask : test_role

  // Five posts into a four-deep buffer; the fifth is dropped
  task automatic test_cpu_mem();
    logic seen;
    logic [31:0] want;
    for (int i = 0; i < 5; i++)
    begin
      step(hpb_pkg::HC_MEMW, 3'h0, 4'h0);
      hd_i = 32'hA5C3_0000 + 32'h0000_1111 * i;
      hp_i = par4(hd_i);
    end
    for (int i = 0; i < 4; i++)
    begin
      step(5'h00, hpb_pkg::MC_DRV_CPU, 4'h0);
      settle();
      want = 32'hA5C3_0000 + 32'h0000_1111 * i;
      chk("md_o", want, md_o);
      chk("mp_o", {28'h0, par4(want)}, {28'h0, mp_o});
      chk("md_oe_b", 32'h0, {31'h0, md_oe_b});
    end
    step(5'h00, hpb_pkg::MC_OFF, 4'h0);
    nop();
    settle();
    chk("md_oe_b off", 32'h1, {31'h0, md_oe_b});
    // Wrong host parity must raise a pulse
    step(hpb_pkg::HC_MEMW, hpb_pkg::MC_CLR, 4'h0);
    hp_i = ~par4(hd_i);
    seen = 1'b0;
    repeat (3)
    begin
      settle();
      seen = seen | h_perr;
      step(5'h00, hpb_pkg::MC_CLR, 4'h0);
    end
    chk("host_perr", 32'h1, {31'h0, seen});
    $display("test cpu_mem done");
  endtask : test_cpu_mem

  task automatic test_pci_write();
    step(hpb_pkg::HC_ADDR, 3'h0, 4'h0);
    ha_i = 16'h1234;
    step(hpb_pkg::HC_PCIW_LO, 3'h0, 4'h0);
    hd_i = 32'h5A5A_C0DE;
    step(hpb_pkg::HC_PCIW_HI, 3'h0, 4'h0);
    ad_pop(hpb_pkg::PC_DRV_ADDR, 16'h1234);
    ad_pop(hpb_pkg::PC_DRV_WD, 16'hC0DE);
    // Second dword leaves on TRDY alone, on the third edge after it falls
    nop();
    trdy_b = 1'b0;
    repeat (3) settle();
    chk("ad_o burst", 32'h0000_5A5A, {16'h0000, ad_o});
    step(5'h00, 3'h0, hpb_pkg::PC_OFF);
    trdy_b = 1'b1;
    nop();
    settle();
    chk("ad_oe_b off", 32'h1, {31'h0, ad_oe_b});
    $display("test pci_write done");
  endtask : test_pci_write

  // Four quadword halves in, eight AD halves out, low half first
  task automatic test_prefetch();
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      step(5'h00, hpb_pkg::MC_PFL, 4'h0);
      bad = bad | m_perr;
      md_en = 1'b1;
      md_val = 32'h1357_8642 + 32'h0101_0101 * i;
    end
    nop();
    bad = bad | m_perr;
    md_en = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      md_val = 32'h1357_8642 + 32'h0101_0101 * (i / 2);
      ad_pop(hpb_pkg::PC_DRV_PF, i[0] ? md_val[31:16] : md_val[15:0]);
    end
    chk("mem_perr", 32'h0, {31'h0, bad});
    $display("test prefetch done");
  endtask : test_prefetch

  task automatic test_host_side();
    step(5'h00, 3'h0, hpb_pkg::PC_RDAT);
    ad_en = 1'b1;
    ad_val = 16'h9A3C;
    step(hpb_pkg::HC_DRV_PFB, 3'h0, 4'h0);
    ad_en = 1'b0;
    nop();
    settle();
    chk("hd_o pfb", 32'h9A3C_9A3C, hd_o);
    chk("hd_oe_b", 32'h0, {31'h0, hd_oe_b});
    step(5'h00, hpb_pkg::MC_HLAT, 4'h0);
    md_en = 1'b1;
    md_val = 32'h0F1E_2D3C;
    step(hpb_pkg::HC_DRV_MEM, 3'h0, 4'h0);
    md_en = 1'b0;
    nop();
    settle();
    chk("hd_o mem", 32'h0F1E_2D3C, hd_o);
    chk("hp_o mem", {28'h0, par4(32'h0F1E_2D3C)}, {28'h0, hp_o});
    step(5'h00, 3'h0, hpb_pkg::PC_MADDR);
    ad_en = 1'b1;
    ad_val = 16'h6E40;
    step(hpb_pkg::HC_SNOOP, 3'h0, 4'h0);
    ad_en = 1'b0;
    nop();
    settle();
    chk("ha_o snoop", 32'h0000_6E40, {16'h0000, ha_o});
    chk("ha_oe_b", 32'h0, {31'h0, ha_oe_b});
    // Unassigned codes must leave every bus released
    step(hpb_pkg::HC_OFF, hpb_pkg::MC_OFF, hpb_pkg::PC_OFF);
    step(5'h1F, 3'h7, 4'hF);
    nop();
    settle();
    chk("oe after nop codes", 32'hF,
      {28'h0, hd_oe_b, ha_oe_b, md_oe_b, ad_oe_b});
    $display("test host_side done");
  endtask : test_host_side

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    strap = 1'b0;
    trdy_b = 1'b1;
    {hcmd, mcmd, pcmd} = 12'h000;
    {hd_i, hp_i, ha_i} = 52'h0;
    {md_en, ad_en, md_val, ad_val} = 50'h0;
    test_role(1'b0);
    test_role(1'b1);
    test_cpu_mem();
    test_pci_write();
    test_prefetch();
    test_host_side();
    report_and_stop();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
endmodule : host_pci_memory_data_slice_bench
`default_nettype wire
